// ### design/boot_strap_config_capture.sv
module boot_strap_config_capture (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic sysResetN,
  input wire logic clockGenResetN,
  input wire logic [bscc_pkg::ADDR_W-1:0] addrStrap,
  input wire logic [bscc_pkg::DATA_W-1:0] dataStrap,
  input wire logic pllSkipN,
  input wire logic [bscc_pkg::TEST_W-1:0] testModeN,
  input wire logic haltState,
  input wire logic dozeState,
  input wire logic [bscc_pkg::REG_AW-1:0] regAddr,
  input wire logic [bscc_pkg::REG_DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [bscc_pkg::REG_DW-1:0] regRdData_ff,
  output logic lowPowerStateOut_ff,
  output logic clockGenInit_ff,
  output bscc_pkg::bscc_pci_mode_t pciMode_ff,
  output logic [bscc_pkg::PCI_RATIO_W-1:0] pciClkDiv_ff,
  output logic pciExtArbiter_ff,
  output logic [bscc_pkg::EXT_RATIO_W-1:0] extBusDiv_ff,
  output logic [bscc_pkg::EBC_DIV_W-1:0] ebcBootDiv_ff,
  output logic byteWriteEnSel_ff,
  output logic extAckSel_ff,
  output logic [bscc_pkg::WIDTH_W-1:0] bootWidth_ff,
  output logic [bscc_pkg::CORE_MUL_W-1:0] coreClkMul_ff,
  output logic ethPciSlow_ff,
  output logic [bscc_pkg::SHARE_W-1:0] sharedPinSel_ff,
  output bscc_pkg::bscc_endian_t endian_ff,
  output logic timerIntEn_ff,
  output logic [bscc_pkg::BOARD_W-1:0] boardInfo_ff
);

  localparam int SYNC_W = bscc_pkg::ADDR_W + bscc_pkg::DATA_W + bscc_pkg::TEST_W + 3;
  localparam int CAP_W = bscc_pkg::ADDR_W + bscc_pkg::DATA_W;

  function automatic logic [bscc_pkg::EXT_RATIO_W-1:0] ext_div(
    input logic [bscc_pkg::DIV2_W-1:0] code
  );
    case (code)
      bscc_pkg::EXT_CODE_LL: ext_div = bscc_pkg::EXT_RATIO_LL;
      bscc_pkg::EXT_CODE_LH: ext_div = bscc_pkg::EXT_RATIO_LH;
      bscc_pkg::EXT_CODE_HL: ext_div = bscc_pkg::EXT_RATIO_HL;
      default: ext_div = bscc_pkg::EXT_RATIO_HH;
    endcase
  endfunction

  function automatic logic [bscc_pkg::PCI_RATIO_W-1:0] pci_div(
    input logic [bscc_pkg::DIV2_W-1:0] code
  );
    pci_div = bscc_pkg::PCI_DIV_BASE + {{(bscc_pkg::PCI_RATIO_W - bscc_pkg::DIV2_W){1'b0}}, code};
  endfunction

  // every reset and strap pin passes two flops; resets and straps share one synchroniser so
  // the strap sample lines up with the synchronised reset edge
  logic [SYNC_W-1:0] syncBus;
  logic [bscc_pkg::ADDR_W-1:0] addrSync;
  logic [bscc_pkg::DATA_W-1:0] dataSync;
  logic [bscc_pkg::TEST_W-1:0] testSync;
  logic pllSkipSync;
  logic sysRstSync;
  logic cgRstSync;

  bscc_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .pinIn({sysResetN, clockGenResetN, pllSkipN, testModeN, addrStrap, dataStrap}),
    .syncOut(syncBus)
  );

  assign {sysRstSync, cgRstSync, pllSkipSync, testSync, addrSync, dataSync} = syncBus;

  // release edge detectors read only the second synchroniser stage
  logic sysRstPrev_ff;
  logic cgRstPrev_ff;
  logic sysRelease;
  logic cgRelease;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sysRstPrev_ff <= 1'b1;
      cgRstPrev_ff <= 1'b1;
    end else if (clkEn) begin
      sysRstPrev_ff <= sysRstSync;
      cgRstPrev_ff <= cgRstSync;
    end
  end

  assign sysRelease = sysRstSync && !sysRstPrev_ff;
  assign cgRelease = cgRstSync && !cgRstPrev_ff;

  // both groups take the full strap word; each field but the timer enable is read
  // from the group whose reset owns it
  logic [CAP_W-1:0] sysCap;
  logic [CAP_W-1:0] cgCap;
  logic [bscc_pkg::ADDR_W-1:0] sysA;
  logic [bscc_pkg::DATA_W-1:0] sysD;
  logic [bscc_pkg::ADDR_W-1:0] cgA;
  logic [bscc_pkg::DATA_W-1:0] unusedCgD;

  bscc_capture #(.W(CAP_W)) u_sys_cap (
    .clk(clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .load(sysRelease),
    .d({addrSync, dataSync}),
    .q_ff(sysCap)
  );

  bscc_capture #(.W(CAP_W)) u_cg_cap (
    .clk(clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .load(cgRelease),
    .d({addrSync, dataSync}),
    .q_ff(cgCap)
  );

  assign {sysA, sysD} = sysCap;
  assign {cgA, unusedCgD} = cgCap;

  logic sysCaptured_ff;
  logic cgCaptured_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sysCaptured_ff <= 1'b0;
      cgCaptured_ff <= 1'b0;
    end else if (clkEn) begin
      if (sysRelease) begin
        sysCaptured_ff <= 1'b1;
      end
      if (cgRelease) begin
        cgCaptured_ff <= 1'b1;
      end
    end
  end

  // clock-generator group
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pciClkDiv_ff <= pci_div('1);
      extBusDiv_ff <= bscc_pkg::EXT_RATIO_HH;
      coreClkMul_ff <= '1;
      ethPciSlow_ff <= 1'b1;
    end else if (clkEn) begin
      pciClkDiv_ff <= pci_div(cgA[bscc_pkg::A_PCI_DIV_LO +: bscc_pkg::DIV2_W]);
      extBusDiv_ff <= ext_div(cgA[bscc_pkg::A_EXT_DIV_LO +: bscc_pkg::DIV2_W]);
      coreClkMul_ff <= cgA[bscc_pkg::A_CORE_MUL_LO +: bscc_pkg::CORE_MUL_W];
      ethPciSlow_ff <= cgA[bscc_pkg::A_ETH_PCI];
    end
  end

  // system-reset group
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pciMode_ff <= bscc_pkg::BSCC_PCI_HOST;
      pciExtArbiter_ff <= 1'b1;
      ebcBootDiv_ff <= '1;
      byteWriteEnSel_ff <= 1'b1;
      extAckSel_ff <= 1'b1;
      bootWidth_ff <= '1;
      sharedPinSel_ff <= '1;
      endian_ff <= bscc_pkg::BSCC_BIG_ENDIAN;
      boardInfo_ff <= '1;
    end else if (clkEn) begin
      pciMode_ff <= bscc_pkg::bscc_pci_mode_t'(sysA[bscc_pkg::A_PCI_MODE]);
      pciExtArbiter_ff <= sysD[bscc_pkg::D_ARB_SEL];
      ebcBootDiv_ff <= sysA[bscc_pkg::A_EBC_DIV_LO +: bscc_pkg::EBC_DIV_W];
      byteWriteEnSel_ff <= sysD[bscc_pkg::D_BE_SEL];
      extAckSel_ff <= sysD[bscc_pkg::D_ACK_SEL];
      bootWidth_ff <= sysD[bscc_pkg::D_WIDTH_LO +: bscc_pkg::WIDTH_W];
      sharedPinSel_ff <= {sysA[bscc_pkg::A_SHARE_HI], sysA[bscc_pkg::A_SHARE_LO],
                          sysD[bscc_pkg::D_SHARE_HI], sysD[bscc_pkg::D_SHARE_LO]};
      endian_ff <= bscc_pkg::bscc_endian_t'(sysA[bscc_pkg::A_ENDIAN]);
      boardInfo_ff <= sysD[bscc_pkg::D_BOARD_LO +: bscc_pkg::BOARD_W];
    end
  end

  // timer enable loads from its strap, software may change it afterwards;
  // a release in the same cycle as a write wins so the strap is never lost
  logic ctrlHit;
  assign ctrlHit = regWr && (regAddr == bscc_pkg::OFS_CTRL);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timerIntEn_ff <= 1'b1;
    end else if (clkEn) begin
      if (sysRelease) begin
        timerIntEn_ff <= dataSync[bscc_pkg::D_TIMER];
      end else if (ctrlHit) begin
        timerIntEn_ff <= regWrData[bscc_pkg::CTRL_TIMER];
      end
    end
  end

  // halt and doze come from core logic on this clock, so no synchroniser
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lowPowerStateOut_ff <= 1'b0;
    end else if (clkEn) begin
      lowPowerStateOut_ff <= haltState || dozeState;
    end
  end

  // initialise stays asserted for the whole synchronised reset pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clockGenInit_ff <= 1'b1;
    end else if (clkEn) begin
      clockGenInit_ff <= !cgRstSync;
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads zero
  logic [bscc_pkg::REG_DW-1:0] rdMux;

  always_comb begin
    rdMux = '0;
    case (regAddr)
      bscc_pkg::OFS_CLKCFG: rdMux = {{(bscc_pkg::REG_DW - 9){1'b0}}, cgA[bscc_pkg::A_ETH_PCI],
                                     cgA[bscc_pkg::A_EXT_DIV_LO +: bscc_pkg::DIV2_W],
                                     cgA[bscc_pkg::A_PCI_DIV_LO +: bscc_pkg::DIV2_W],
                                     cgA[bscc_pkg::A_CORE_MUL_LO +: bscc_pkg::CORE_MUL_W]};
      bscc_pkg::OFS_SYSCFG: rdMux = {{(bscc_pkg::REG_DW - bscc_pkg::ADDR_W){1'b0}}, sysA};
      bscc_pkg::OFS_BOARD: rdMux = {{(bscc_pkg::REG_DW - bscc_pkg::DATA_W){1'b0}}, sysD};
      // pll skip and test levels only reported
      bscc_pkg::OFS_STATUS: rdMux = {{(bscc_pkg::REG_DW - bscc_pkg::TEST_W - 3){1'b0}},
                                     testSync, pllSkipSync, cgCaptured_ff, sysCaptured_ff};
      bscc_pkg::OFS_CTRL: rdMux = {{(bscc_pkg::REG_DW - 1){1'b0}}, timerIntEn_ff};
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regRdData_ff <= '0;
    end else if (clkEn) begin
      regRdData_ff <= regRd ? rdMux : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_lowpow_on;
    (clkEn && (haltState || dozeState)) |=> lowPowerStateOut_ff;
  endproperty
  a_lowpow_on: assert property (p_lowpow_on) else $error("indicator not high in halt/doze");

  property p_lowpow_off;
    (clkEn && !haltState && !dozeState) |=> !lowPowerStateOut_ff;
  endproperty
  a_lowpow_off: assert property (p_lowpow_off) else $error("indicator high while running");

  property p_cg_init;
    (clkEn && !cgRstSync) |=> clockGenInit_ff;
  endproperty
  a_cg_init: assert property (p_cg_init) else $error("clock gen not initialised");

  property p_sys_sample;
    (clkEn && sysRelease) |=> (sysCap == $past({addrSync, dataSync}));
  endproperty
  a_sys_sample: assert property (p_sys_sample) else $error("system strap sample wrong");

  property p_cg_sample;
    (clkEn && cgRelease) |=> (cgCap == $past({addrSync, dataSync}));
  endproperty
  a_cg_sample: assert property (p_cg_sample) else $error("clock strap sample wrong");

  property p_hold;
    (!sysRelease && !cgRelease) |=> ($stable(sysCap) && $stable(cgCap));
  endproperty
  a_hold: assert property (p_hold) else $error("captured straps changed");

  property p_pci_mode;
    (clkEn && sysRelease) ##1 clkEn |=> (pciMode_ff == $past(addrSync[bscc_pkg::A_PCI_MODE], 2));
  endproperty
  a_pci_mode: assert property (p_pci_mode) else $error("pci mode not from strap");

  property p_ext_div;
    (clkEn && cgRelease) ##1 clkEn |=>
      (extBusDiv_ff == ext_div($past(addrSync[bscc_pkg::A_EXT_DIV_LO +: bscc_pkg::DIV2_W], 2)));
  endproperty
  a_ext_div: assert property (p_ext_div) else $error("external divide decode wrong");

  property p_endian;
    (clkEn && sysRelease) ##1 clkEn |=> (endian_ff == $past(addrSync[bscc_pkg::A_ENDIAN], 2));
  endproperty
  a_endian: assert property (p_endian) else $error("endian not from strap");

endmodule

// ### design/bscc_pkg.sv
package bscc_pkg;

  // strap bus widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int TEST_W = 5;

  // register port widths
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  // address strap positions
  localparam int A_PCI_MODE = 19;
  localparam int A_SHARE_HI = 18;
  localparam int A_ETH_PCI = 16;
  localparam int A_EXT_DIV_LO = 13;
  localparam int A_ENDIAN = 12;
  localparam int A_PCI_DIV_LO = 10;
  localparam int A_SHARE_LO = 9;
  localparam int A_EBC_DIV_LO = 6;
  localparam int A_CORE_MUL_LO = 0;

  // data strap positions
  localparam int D_BOARD_LO = 8;
  localparam int D_TIMER = 7;
  localparam int D_SHARE_HI = 6;
  localparam int D_BE_SEL = 5;
  localparam int D_ACK_SEL = 4;
  localparam int D_SHARE_LO = 3;
  localparam int D_ARB_SEL = 2;
  localparam int D_WIDTH_LO = 0;

  // field widths
  localparam int DIV2_W = 2;
  localparam int EBC_DIV_W = 3;
  localparam int CORE_MUL_W = 4;
  localparam int PCI_RATIO_W = 4;
  localparam int EXT_RATIO_W = 3;
  localparam int WIDTH_W = 2;
  localparam int BOARD_W = 8;
  localparam int SHARE_W = 4;

  // pci clock divide is a base ratio plus the strap code
  localparam logic [PCI_RATIO_W-1:0] PCI_DIV_BASE = 4'h8;

  // external bus divide decode
  localparam logic [DIV2_W-1:0] EXT_CODE_LL = 2'h0;
  localparam logic [DIV2_W-1:0] EXT_CODE_LH = 2'h1;
  localparam logic [DIV2_W-1:0] EXT_CODE_HL = 2'h2;
  localparam logic [EXT_RATIO_W-1:0] EXT_RATIO_LL = 3'h4;
  localparam logic [EXT_RATIO_W-1:0] EXT_RATIO_LH = 3'h3;
  localparam logic [EXT_RATIO_W-1:0] EXT_RATIO_HL = 3'h2;
  localparam logic [EXT_RATIO_W-1:0] EXT_RATIO_HH = 3'h1;

  // register byte offsets
  localparam logic [REG_AW-1:0] OFS_CLKCFG = 8'h00;
  localparam logic [REG_AW-1:0] OFS_SYSCFG = 8'h04;
  localparam logic [REG_AW-1:0] OFS_BOARD = 8'h08;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h10;

  localparam int CTRL_TIMER = 0;

  typedef enum logic {
    BSCC_PCI_SATELLITE = 1'b0,
    BSCC_PCI_HOST = 1'b1
  } bscc_pci_mode_t;

  typedef enum logic {
    BSCC_LITTLE_ENDIAN = 1'b0,
    BSCC_BIG_ENDIAN = 1'b1
  } bscc_endian_t;

endpackage

// ### design/bscc_sync.sv
// two-stage synchroniser; reset value ones so pulled-up pins read high
module bscc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_ff <= '1;
      syncOut <= '1;
    end else if (clkEn) begin
      meta_ff <= pinIn;
      syncOut <= meta_ff;
    end
  end

endmodule

// ### design/bscc_capture.sv
// holds a strap snapshot; only a load pulse or reset, which loads all ones, changes it
module bscc_capture #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_ff
);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q_ff <= '1;
    end else if (clkEn && load) begin
      q_ff <= d;
    end
  end

endmodule

// ### bench/bscc_board.sv
module bscc_board (
  input wire logic sysHold,
  input wire logic cgHold,
  input wire logic [bscc_pkg::ADDR_W-1:0] addrVal,
  input wire logic [bscc_pkg::ADDR_W-1:0] addrEn,
  input wire logic [bscc_pkg::DATA_W-1:0] dataVal,
  input wire logic [bscc_pkg::DATA_W-1:0] dataEn,
  input wire logic [bscc_pkg::TEST_W-1:0] testLow,
  output logic sysResetN,
  output logic clockGenResetN,
  output logic [bscc_pkg::ADDR_W-1:0] addrStrap,
  output logic [bscc_pkg::DATA_W-1:0] dataStrap,
  output logic pllSkipN,
  output logic [bscc_pkg::TEST_W-1:0] testModeN
);
  timeunit 1ns;
  timeprecision 1ns;
  assign sysResetN = !sysHold;
  assign clockGenResetN = !cgHold;
  // a pin without a pull-down resistor floats to the pull-up level
  assign addrStrap = (addrVal & addrEn) | ~addrEn;
  assign dataStrap = (dataVal & dataEn) | ~dataEn;
  assign pllSkipN = 1'b1;
  // only a debug session pulls a test pin low
  assign testModeN = ~testLow;
endmodule

// ### bench/tb_boot_strap_config_capture.sv
module tb_boot_strap_config_capture;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [19:0] aVal;
    logic [19:0] aEn;
    logic [15:0] dVal;
    logic [15:0] dEn;
    logic [2:0] extDiv;
  } bscc_row_t;
  logic clk, rst_b, haltState, dozeState, regWr, regRd, sysHold, cgHold;
  logic sysResetN, clockGenResetN, pllSkipN, lowPowerStateOut_ff, clockGenInit_ff;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData_ff;
  logic [19:0] addrVal, addrEn, addrStrap, sysA, cgA;
  logic [15:0] dataVal, dataEn, dataStrap, sysD;
  logic [4:0] testLow, testModeN;
  logic expTimer, clkEn;
  bscc_pkg::bscc_pci_mode_t pciMode_ff;
  bscc_pkg::bscc_endian_t endian_ff;
  logic [3:0] pciClkDiv_ff, coreClkMul_ff, sharedPinSel_ff;
  logic [2:0] extBusDiv_ff, ebcBootDiv_ff;
  logic [1:0] bootWidth_ff;
  logic [7:0] boardInfo_ff;
  logic pciExtArbiter_ff, byteWriteEnSel_ff, extAckSel_ff, ethPciSlow_ff, timerIntEn_ff;
  int fails, checksDone, cycles;
  bscc_row_t rows [5];

  bscc_board board (.sysHold(sysHold), .cgHold(cgHold), .addrVal(addrVal), .addrEn(addrEn),
    .dataVal(dataVal), .dataEn(dataEn), .testLow(testLow), .sysResetN(sysResetN),
    .clockGenResetN(clockGenResetN), .addrStrap(addrStrap), .dataStrap(dataStrap),
    .pllSkipN(pllSkipN), .testModeN(testModeN));

  boot_strap_config_capture dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .sysResetN(sysResetN), .clockGenResetN(clockGenResetN), .addrStrap(addrStrap),
    .dataStrap(dataStrap), .pllSkipN(pllSkipN), .testModeN(testModeN),
    .haltState(haltState), .dozeState(dozeState), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff),
    .lowPowerStateOut_ff(lowPowerStateOut_ff), .clockGenInit_ff(clockGenInit_ff),
    .pciMode_ff(pciMode_ff), .pciClkDiv_ff(pciClkDiv_ff), .pciExtArbiter_ff(pciExtArbiter_ff),
    .extBusDiv_ff(extBusDiv_ff), .ebcBootDiv_ff(ebcBootDiv_ff),
    .byteWriteEnSel_ff(byteWriteEnSel_ff), .extAckSel_ff(extAckSel_ff),
    .bootWidth_ff(bootWidth_ff), .coreClkMul_ff(coreClkMul_ff), .ethPciSlow_ff(ethPciSlow_ff),
    .sharedPinSel_ff(sharedPinSel_ff), .endian_ff(endian_ff), .timerIntEn_ff(timerIntEn_ff),
    .boardInfo_ff(boardInfo_ff));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report();
    if (fails == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // far more than the sequence needs; a stuck wait ends the run here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone = checksDone + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sys-owned fields come from the last system release, the rest from the last clock-gen release
  task automatic chkAll();
    chk(pciMode_ff, sysA[19]);
    chk(pciClkDiv_ff, 4'h8 + cgA[11:10]);
    chk(pciExtArbiter_ff, sysD[2]);
    chk(extBusDiv_ff, 3'h4 - {1'b0, cgA[14:13]});
    chk(ebcBootDiv_ff, sysA[8:6]);
    chk(byteWriteEnSel_ff, sysD[5]);
    chk(extAckSel_ff, sysD[4]);
    chk(bootWidth_ff, sysD[1:0]);
    chk(coreClkMul_ff, cgA[3:0]);
    chk(ethPciSlow_ff, cgA[16]);
    chk(sharedPinSel_ff, {sysA[18], sysA[9], sysD[6], sysD[3]});
    chk(endian_ff, sysA[12]);
    chk(timerIntEn_ff, expTimer);
    chk(boardInfo_ff, sysD[15:8]);
  endtask

  task automatic boot(input logic sys, input logic cg, input bscc_row_t r);
    @(posedge clk);
    sysHold <= sys;
    cgHold <= cg;
    addrVal <= r.aVal;
    addrEn <= r.aEn;
    dataVal <= r.dVal;
    dataEn <= r.dEn;
    repeat (5) @(posedge clk);
    #1 chk(clockGenInit_ff, cg);
    @(posedge clk);
    sysHold <= 1'b0;
    cgHold <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    if (sys) begin
      sysA = (r.aVal & r.aEn) | ~r.aEn;
      sysD = (r.dVal & r.dEn) | ~r.dEn;
      expTimer = sysD[7];
    end
    if (cg) cgA = (r.aVal & r.aEn) | ~r.aEn;
    chk(clockGenInit_ff, 1'b0);
    chkAll();
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdData_ff, exp);
    @(posedge clk);
    #1 chk(regRdData_ff, 32'h0);
  endtask

  initial begin
    {rst_b, haltState, dozeState, regWr, regRd, sysHold, cgHold} = '0;
    {regAddr, regWrData, addrVal, addrEn, dataVal, dataEn, testLow} = '0;
    {fails, checksDone, cycles} = '0;
    clkEn = 1'b1;
    {sysA, cgA, sysD, expTimer} = '1;
    rows[0] = {20'h00000, 20'hfffff, 16'h0000, 16'hffff, 3'h4};
    rows[1] = {20'h02000, 20'hfffff, 16'h5a5a, 16'hffff, 3'h3};
    rows[2] = {20'ha5a5a, 20'hfffff, 16'ha5a5, 16'hffff, 3'h2};
    rows[3] = {20'h00000, 20'h00000, 16'h0000, 16'h0000, 3'h1};
    rows[4] = {20'h00000, 20'h06000, 16'h0000, 16'h00ff, 3'h4};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk(lowPowerStateOut_ff, 1'b0);
    chk(clockGenInit_ff, 1'b1);
    chk(regRdData_ff, 32'h0);
    chkAll();
    foreach (rows[i]) begin
      boot(1'b1, 1'b1, rows[i]);
      chk(extBusDiv_ff, rows[i].extDiv);
    end
    // pins return to bus duty; settings must not follow them
    @(posedge clk);
    addrEn <= '1;
    dataEn <= '1;
    addrVal <= 20'h5a5a5;
    dataVal <= 16'h5a5a;
    repeat (8) @(posedge clk);
    #1 chkAll();
    boot(1'b0, 1'b1, rows[2]);
    boot(1'b1, 1'b0, rows[1]);
    regRead(bscc_pkg::OFS_BOARD, {16'h0, sysD});
    regRead(bscc_pkg::OFS_SYSCFG, {12'h0, sysA});
    regRead(bscc_pkg::OFS_CLKCFG, {23'h0, cgA[16], cgA[14:13], cgA[11:10], cgA[3:0]});
    regRead(bscc_pkg::OFS_STATUS, 32'h000000ff);
    @(posedge clk);
    testLow <= 5'h02;
    repeat (5) @(posedge clk);
    regRead(bscc_pkg::OFS_STATUS, 32'h000000ef);
    regWrite(bscc_pkg::OFS_CTRL, {31'h0, ~expTimer});
    expTimer = ~expTimer;
    #1 chk(timerIntEn_ff, expTimer);
    regRead(bscc_pkg::OFS_CTRL, {31'h0, expTimer});
    regWrite(bscc_pkg::OFS_CLKCFG, 32'hffffffff);
    regRead(bscc_pkg::OFS_CLKCFG, {23'h0, cgA[16], cgA[14:13], cgA[11:10], cgA[3:0]});
    regRead(8'h14, 32'h0);
    // a system release reloads the timer enable over the software value
    boot(1'b1, 1'b0, rows[1]);
    @(posedge clk);
    haltState <= 1'b1;
    #1 chk(lowPowerStateOut_ff, 1'b0);
    @(posedge clk);
    haltState <= 1'b0;
    dozeState <= 1'b1;
    #1 chk(lowPowerStateOut_ff, 1'b1);
    @(posedge clk);
    dozeState <= 1'b0;
    #1 chk(lowPowerStateOut_ff, 1'b1);
    @(posedge clk);
    #1 chk(lowPowerStateOut_ff, 1'b0);
    // a frozen clock enable must hold every flop, the indicator included
    @(posedge clk);
    clkEn <= 1'b0;
    haltState <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(lowPowerStateOut_ff, 1'b0);
    @(posedge clk);
    clkEn <= 1'b1;
    @(posedge clk);
    #1 chk(lowPowerStateOut_ff, 1'b1);
    // mid-run reset: captures fall back to the pulled-up value and stay there
    @(posedge clk);
    rst_b <= 1'b0;
    haltState <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    {sysA, cgA, sysD, expTimer} = '1;
    #1 chk(lowPowerStateOut_ff, 1'b0);
    chk(clockGenInit_ff, 1'b1);
    chkAll();
    @(posedge clk);
    #1 chkAll();
    chk(clockGenInit_ff, 1'b0);
    regRead(bscc_pkg::OFS_STATUS, 32'h000000ec);
    final_report();
  end
endmodule
